// [core/ctm_channel_ctrl.v]
// Function
// - function 16 copies the whole 16-bit accumulator into target-and-mode
// - low byte is target address 0-255, driven onto outbound bus
// - loading either register leaves busy and done flags unchanged
// - every function 16 rewrites all eight mode bits
// - skip bit 8 suppresses local memory writes during read transfers
// - bit 9 holds the stack-status mode flag
// - bits 11:10 pick chaining: none, channel end, device end, either
// - bits 13:12 pick interrupt: off, request-in, status-in, disconnect-in
// - bits 15:14 pick channel: selector, byte mux, block mux, reserved
// - function 17 loads the accumulator into tag override register
// - override bits 0-9 drive the ten outbound tags in order
// - bit 12 clock out, 13 inhibits parity check, 14 forces parity
// - function 16 also loads the intermediate status register
// - next input-tag read after function 17 returns the override word
`timescale 1ns/1ps
`include "ctm_map.vh"
module ctm_channel_ctrl (
	// clock and reset
	input wire clk_sys_in,
	input wire sys_rst_in,
	// io_processor function port
	input wire block_channel_function_in,
	input wire [4:0] func_code_in,
	input wire [15:0] accum_in,
	// channel state from the transfer logic
	input wire read_xfer_in,
	input wire mem_wr_req_in,
	input wire [7:0] chan_status_in,
	input wire [15:0] input_tags_in,
	input wire busy_set_in,
	input wire done_set_in,
	input wire flags_clr_in,
	// accumulator return
	output reg [15:0] accum_ret_out,
	output reg accum_ret_valid_out,
	// outbound bus and tags
	output reg [7:0] bus_out_addr_out,
	output reg [9:0] tags_out,
	output reg clock_tag_out,
	output reg parity_inhibit_out,
	output reg parity_force_out,
	// mode outputs
	output reg local_mem_wr_out,
	output reg stack_status_out,
	output reg [3:0] chain_mode_out,
	output reg [3:0] intr_mode_out,
	output reg [3:0] chan_type_out,
	// channel flags
	output reg chan_busy_out,
	output reg chan_done_out
);
	reg [15:0] target_q;
	reg [15:0] tags_q;
	reg [15:0] status_q;
	reg [15:0] tag_capture_q;
	reg loop_pending_q;
	reg stat_pending_q;
	wire [3:0] chain_oh;
	wire [3:0] intr_oh;
	wire [3:0] chtype_oh;
	wire [23:0] pin_raw = {input_tags_in, chan_status_in};
	wire [23:0] pin_sync;
	wire [7:0] status_sync;
	wire [15:0] tags_in_sync;
	genvar gi;

	// true when the strobe carries the given function code
	function fn_hit;
		input strobe;
		input [4:0] code;
		input [4:0] want;
		begin
			fn_hit = strobe && (code == want);
		end
	endfunction

	wire fn16 = fn_hit(block_channel_function_in, func_code_in, `CTM_FN_ENTER_TARGET);
	wire fn17 = fn_hit(block_channel_function_in, func_code_in, `CTM_FN_ENTER_TAGS);
	wire fn12 = fn_hit(block_channel_function_in, func_code_in, `CTM_FN_READ_STATUS);
	wire fn13 = fn_hit(block_channel_function_in, func_code_in, `CTM_FN_READ_TAGS);

	// channel pins cross in through three stages; taken once stages two and three agree
	generate
		for (gi = 0; gi < 24; gi = gi + 1) begin : g_pin_sync
			reg meta_q;
			reg mid_q;
			reg late_q;
			reg agreed_q;
			always @(posedge clk_sys_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					meta_q <= 1'b0;
					mid_q <= 1'b0;
					late_q <= 1'b0;
					agreed_q <= 1'b0;
				end else begin
					meta_q <= pin_raw[gi];
					mid_q <= meta_q;
					late_q <= mid_q;
					if (mid_q == late_q)
						agreed_q <= late_q;
				end
			end
			assign pin_sync[gi] = agreed_q;
		end
	endgenerate
	assign status_sync = pin_sync[7:0];
	assign tags_in_sync = pin_sync[23:8];

	ctm_decode u_decode (
		.chain_sel_in(target_q[`CTM_CHAIN_MSB:`CTM_CHAIN_LSB]),
		.intr_sel_in(target_q[`CTM_INTR_MSB:`CTM_INTR_LSB]),
		.chtype_sel_in(target_q[`CTM_CHTYPE_MSB:`CTM_CHTYPE_LSB]),
		.chain_oh_out(chain_oh),
		.intr_oh_out(intr_oh),
		.chtype_oh_out(chtype_oh)
	);

	// programming registers
	always @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			target_q <= `CTM_TARGET_RST;
			tags_q <= `CTM_TAGS_RST;
		end else begin
			if (fn16)
				target_q <= accum_in;
			if (fn17)
				tags_q <= accum_in;
		end
	end

	// status path: a read after a load returns the loaded word, otherwise it
	// returns the held word (still the loaded word on the second read after a load) and captures live address and status for the next read
	always @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			status_q <= 16'h0000;
			stat_pending_q <= 1'b0;
		end else begin
			if (fn16) begin
				status_q <= accum_in;
				stat_pending_q <= 1'b1;
			end else if (fn12) begin
				stat_pending_q <= 1'b0;
				if (!stat_pending_q)
					status_q <= {target_q[`CTM_ADDR_MSB:`CTM_ADDR_LSB], status_sync};
			end
		end
	end

	// tag path: same two-step scheme, loopback of the override word first
	always @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tag_capture_q <= 16'h0000;
			loop_pending_q <= 1'b0;
		end else begin
			if (fn17) begin
				tag_capture_q <= accum_in;
				loop_pending_q <= 1'b1;
			end else if (fn13) begin
				loop_pending_q <= 1'b0;
				if (!loop_pending_q)
					tag_capture_q <= tags_in_sync;
			end
		end
	end

	// read return word and its one-cycle valid pulse
	always @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			accum_ret_out <= 16'h0000;
			accum_ret_valid_out <= 1'b0;
		end else begin
			accum_ret_valid_out <= fn12 || fn13;
			if (fn12)
				accum_ret_out <= status_q;
			else if (fn13)
				accum_ret_out <= tag_capture_q;
		end
	end

	// busy/done are set and cleared only by transfer logic, never by 16/17
	always @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chan_busy_out <= 1'b0;
			chan_done_out <= 1'b0;
		end else begin
			if (busy_set_in)
				chan_busy_out <= 1'b1;
			else if (flags_clr_in)
				chan_busy_out <= 1'b0;
			if (done_set_in)
				chan_done_out <= 1'b1;
			else if (flags_clr_in)
				chan_done_out <= 1'b0;
		end
	end

	// registered outbound drives and mode outputs
	always @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bus_out_addr_out <= 8'h00;
			tags_out <= 10'h000;
			clock_tag_out <= 1'b0;
			parity_inhibit_out <= 1'b0;
			parity_force_out <= 1'b0;
			local_mem_wr_out <= 1'b0;
			stack_status_out <= 1'b0;
			chain_mode_out <= 4'h1;
			intr_mode_out <= 4'h1;
			chan_type_out <= 4'h1;
		end else begin
			bus_out_addr_out <= target_q[`CTM_ADDR_MSB:`CTM_ADDR_LSB];
			tags_out <= tags_q[`CTM_TAG_MSB:`CTM_TAG_LSB];
			clock_tag_out <= tags_q[`CTM_CLKOUT_BIT];
			parity_inhibit_out <= tags_q[`CTM_INHPAR_BIT];
			parity_force_out <= tags_q[`CTM_FRCPAR_BIT];
			local_mem_wr_out <= mem_wr_req_in &&
				!(read_xfer_in && target_q[`CTM_SKIP_BIT]);
			stack_status_out <= target_q[`CTM_STACK_BIT];
			chain_mode_out <= chain_oh;
			intr_mode_out <= intr_oh;
			chan_type_out <= chtype_oh;
		end
	end
endmodule // ctm_channel_ctrl

// [core/ctm_decode.v]
`timescale 1ns/1ps
// decodes the two-bit mode fields into one-hot selects
module ctm_decode (
	// mode fields
	input wire [1:0] chain_sel_in,
	input wire [1:0] intr_sel_in,
	input wire [1:0] chtype_sel_in,
	// decoded selects
	output wire [3:0] chain_oh_out,
	output wire [3:0] intr_oh_out,
	output wire [3:0] chtype_oh_out
);
	function [3:0] one_hot;
		input [1:0] sel;
		begin
			one_hot = 4'h1 << sel;
		end
	endfunction

	assign chain_oh_out = one_hot(chain_sel_in);
	assign intr_oh_out = one_hot(intr_sel_in);
	assign chtype_oh_out = one_hot(chtype_sel_in);
endmodule // ctm_decode

// [core/ctm_map.vh]
`ifndef CTM_MAP_VH
`define CTM_MAP_VH
// channel function codes
`define CTM_FN_ENTER_TARGET 5'h10
`define CTM_FN_ENTER_TAGS 5'h11
`define CTM_FN_READ_STATUS 5'h0c
`define CTM_FN_READ_TAGS 5'h0d
// target-and-mode register fields
`define CTM_ADDR_LSB 0
`define CTM_ADDR_MSB 7
`define CTM_SKIP_BIT 8
`define CTM_STACK_BIT 9
`define CTM_CHAIN_LSB 10
`define CTM_CHAIN_MSB 11
`define CTM_INTR_LSB 12
`define CTM_INTR_MSB 13
`define CTM_CHTYPE_LSB 14
`define CTM_CHTYPE_MSB 15
// tag override register fields
`define CTM_TAG_LSB 0
`define CTM_TAG_MSB 9
`define CTM_CLKOUT_BIT 12
`define CTM_INHPAR_BIT 13
`define CTM_FRCPAR_BIT 14
// reset values
`define CTM_TARGET_RST 16'h0000
`define CTM_TAGS_RST 16'h0000
`endif

// [test/channel_target_mode_and_tag_control_test.sv]
`timescale 1ns/1ps
module channel_target_mode_and_tag_control_test;
reg clk_sys_in = 0, sys_rst_in = 1, stb = 0, rx = 0, wr = 0, bs = 0, ds = 0, cl = 0;
reg [4:0] fc = 0;
reg [15:0] acc = 0;
reg [1:0] m;
wire [7:0] st, ad;
wire [15:0] it, ret;
wire [9:0] tg;
wire [3:0] cm, im, ct;
wire rv, ck, pi, pf, lw, ss, by, dn;
integer n_mismatch = 0, tests_run = 0, k, w;
always #50 clk_sys_in = ~clk_sys_in;
ctm_channel_ctrl dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
	.block_channel_function_in(stb), .func_code_in(fc), .accum_in(acc), .read_xfer_in(rx),
	.mem_wr_req_in(wr), .chan_status_in(st), .input_tags_in(it), .busy_set_in(bs),
	.done_set_in(ds), .flags_clr_in(cl), .accum_ret_out(ret), .accum_ret_valid_out(rv),
	.bus_out_addr_out(ad), .tags_out(tg), .clock_tag_out(ck), .parity_inhibit_out(pi),
	.parity_force_out(pf), .local_mem_wr_out(lw), .stack_status_out(ss),
	.chain_mode_out(cm), .intr_mode_out(im), .chan_type_out(ct), .chan_busy_out(by),
	.chan_done_out(dn));
ctm_periph_model pm (.bus_out_addr_in(ad), .chan_status_out(st), .input_tags_out(it));
task chk(input [31:0] s, input [31:0] e); begin
	tests_run = tests_run + 1;
	if (s !== e) begin
		n_mismatch = n_mismatch + 1;
		$display("mismatch at %0t seen %h expected %h", $time, s, e);
	end
end endtask
task fn(input [4:0] c, input [15:0] a); begin
	@(negedge clk_sys_in);
	stb = 1; fc = c; acc = a;
	@(negedge clk_sys_in);
	stb = 0;
	repeat (2) @(negedge clk_sys_in);
end endtask
task rd(input [4:0] c, input [15:0] e); begin
	@(negedge clk_sys_in);
	stb = 1;
	fc = c;
	acc = 16'h0000;
	@(negedge clk_sys_in);
	stb = 0;
	chk(rv, 1'b1);
	@(negedge clk_sys_in);
	chk(rv, 1'b0);
	chk(ret, e);
	@(negedge clk_sys_in);
end endtask
task t_target; begin
	for (k = 0; k < 4; k = k + 1) begin
		m = k;
		fn(5'h10, {m, m, m, 2'b10, 6'h3f, m});
		chk(ad, {6'h3f, m});
		chk(cm, 4'h1 << m);
		chk(im, 4'h1 << m);
		chk(ct, 4'h1 << m);
		chk(ss, 1'b1);
	end
	fn(5'h10, 16'h0000);
	chk({ss, cm, im, ct, ad}, {1'b0, 12'h111, 8'h00});
	fn(5'h10, 16'h5a3c);
	chk({ct, im, cm, ss, ad}, {4'h2, 4'h2, 4'h4, 1'b1, 8'h3c});
	rd(5'h0c, 16'h5a3c);
	rd(5'h0c, 16'h5a3c);
	rd(5'h0c, 16'h3cc3);
	$display("test target done");
end endtask
task t_tags; begin
	fn(5'h11, 16'h73ff);
	chk(tg, 10'h3ff);
	chk({pf, pi, ck}, 3'h7);
	rd(5'h0d, 16'h73ff);
	fn(5'h11, 16'h1155);
	chk({pf, pi, ck, tg}, 13'h0555);
	rd(5'h0d, 16'h1155);
	rd(5'h0d, 16'h1155);
	rd(5'h0d, 16'h003c);
	$display("test tags done");
end endtask
task t_flags; begin
	@(negedge clk_sys_in);
	bs = 1;
	@(negedge clk_sys_in);
	bs = 0;
	fn(5'h10, 16'h0001);
	fn(5'h11, 16'h0002);
	chk({by, dn}, 2'b10);
	@(negedge clk_sys_in);
	ds = 1;
	@(negedge clk_sys_in);
	ds = 0;
	fn(5'h10, 16'h0003);
	fn(5'h11, 16'h0004);
	chk({by, dn}, 2'b11);
	@(negedge clk_sys_in);
	cl = 1;
	@(negedge clk_sys_in);
	cl = 0;
	fn(5'h11, 16'h0000);
	chk({by, dn}, 2'b00);
	$display("test flags done");
end endtask
task t_skip; begin
	fn(5'h10, 16'h0100);
	rx = 1; wr = 1;
	repeat (2) @(negedge clk_sys_in);
	chk(lw, 1'b0);
	rx = 0;
	repeat (2) @(negedge clk_sys_in);
	chk(lw, 1'b1);
	wr = 0;
	fn(5'h10, 16'h0000);
	rx = 1;
	wr = 1;
	repeat (2) @(negedge clk_sys_in);
	chk(lw, 1'b1);
	rx = 0;
	wr = 0;
	repeat (2) @(negedge clk_sys_in);
	chk(lw, 1'b0);
	$display("test skip done");
end endtask
task complete_run; begin
	$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
	if (n_mismatch == 0 && tests_run > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
end endtask
task t_power_up; begin
	chk({tg, ad}, 18'h0);
	chk({cm, im, ct}, 12'h111);
	$display("test power up done");
end endtask
task t_command; begin
	fn(5'h0e, 16'h0000);
	fn(5'h0f, 16'h0000);
	fn(5'h10, 16'h0015);
	chk(ad, 8'h15);
	@(negedge clk_sys_in);
	ds = 1;
	@(negedge clk_sys_in);
	ds = 0;
	w = 0;
	while (dn !== 1'b1 && w < 8) begin
		@(negedge clk_sys_in);
		w = w + 1;
	end
	chk(dn, 1'b1);
	if (dn !== 1'b1)
		complete_run;
	$display("test command done");
end endtask
task t_reset; begin
	fn(5'h10, 16'hffff);
	fn(5'h11, 16'hffff);
	@(negedge clk_sys_in);
	sys_rst_in = 1;
	@(negedge clk_sys_in);
	chk({ss, lw, by, dn, ck, pi, pf, tg, ad}, 25'h0);
	chk({cm, im, ct}, 12'h111);
	chk({rv, ret}, 17'h0);
	repeat (2) @(negedge clk_sys_in);
	sys_rst_in = 0;
	@(negedge clk_sys_in);
	chk({tg, ad}, 18'h0);
	rd(5'h0d, 16'h0000);
	$display("test reset done");
end endtask
initial begin
	repeat (3) @(negedge clk_sys_in);
	sys_rst_in = 0;
	t_power_up;
	t_target;
	t_tags;
	t_flags;
	t_skip;
	t_command;
	t_reset;
	complete_run;
end
endmodule // channel_target_mode_and_tag_control_test

// [test/ctm_channel_ctrl_assertions.sv]
`timescale 1ns/1ps
module ctm_channel_ctrl_chk (
	input wire clk_sys_in,
	input wire sys_rst_in,
	input wire block_channel_function_in,
	input wire [4:0] func_code_in,
	input wire [15:0] accum_in,
	input wire read_xfer_in,
	input wire mem_wr_req_in,
	input wire busy_set_in,
	input wire done_set_in,
	input wire flags_clr_in,
	input wire accum_ret_valid_out,
	input wire chan_busy_out,
	input wire chan_done_out,
	input wire [7:0] bus_out_addr_out,
	input wire [9:0] tags_out,
	input wire clock_tag_out,
	input wire parity_inhibit_out,
	input wire parity_force_out,
	input wire local_mem_wr_out,
	input wire stack_status_out,
	input wire [3:0] chain_mode_out,
	input wire [3:0] intr_mode_out,
	input wire [3:0] chan_type_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (sys_rst_in);
sequence ld16; block_channel_function_in && func_code_in == 5'h10; endsequence
sequence ld17; block_channel_function_in && func_code_in == 5'h11; endsequence
AST_ADDR: assert property (ld16 |-> ##2 bus_out_addr_out == $past(accum_in[7:0], 2))
	else $error("target address not loaded");
AST_STACK: assert property (ld16 |-> ##2 stack_status_out == $past(accum_in[9], 2))
	else $error("stack flag not loaded");
AST_CHAIN: assert property (ld16 |-> ##2 chain_mode_out == 4'h1 << $past(accum_in[11:10], 2))
	else $error("chain mode wrong");
AST_INTR: assert property (ld16 |-> ##2 intr_mode_out == 4'h1 << $past(accum_in[13:12], 2))
	else $error("interrupt mode wrong");
AST_TYPE: assert property (ld16 |-> ##2 chan_type_out == 4'h1 << $past(accum_in[15:14], 2))
	else $error("channel type wrong");
AST_TAGS: assert property (ld17 |-> ##2 tags_out == $past(accum_in[9:0], 2))
	else $error("outbound tags wrong");
AST_DIAG: assert property (ld17 |-> ##2 {parity_force_out, parity_inhibit_out, clock_tag_out}
	== $past(accum_in[14:12], 2)) else $error("diagnostic tags wrong");
AST_MEMWR: assert property (mem_wr_req_in && !read_xfer_in |=> local_mem_wr_out)
	else $error("memory write dropped");
AST_VALID: assert property (block_channel_function_in &&
	(func_code_in == 5'h0c || func_code_in == 5'h0d) |=> accum_ret_valid_out)
	else $error("read return not flagged");
AST_VALID_ONE: assert property (!block_channel_function_in |=> !accum_ret_valid_out)
	else $error("read valid without a read");
AST_FLAGS: assert property (block_channel_function_in && func_code_in[4:1] == 4'h8 &&
	!busy_set_in && !done_set_in && !flags_clr_in |=>
	$stable(chan_busy_out) && $stable(chan_done_out)) else $error("flags moved on a load");
endmodule // ctm_channel_ctrl_chk
bind ctm_channel_ctrl ctm_channel_ctrl_chk chk (.*);

// [test/ctm_periph_model.sv]
`timescale 1ns/1ps
module ctm_periph_model (
	input wire [7:0] bus_out_addr_in,
	output wire [7:0] chan_status_out,
	output wire [15:0] input_tags_out
);
// the selected unit answers with status and tags derived from its address
assign chan_status_out = ~bus_out_addr_in;
assign input_tags_out = {8'h00, bus_out_addr_in};
endmodule // ctm_periph_model
